// file: core/pcc_pll_config.sv
// Purpose : apb register file holding the pll clock multiplier configuration
// Assumes : apb master on i_clock; auto band input is on the same clock
// Notes   : zero-wait slave answering one cycle after setup; unmapped address errors
// Summary of operation
// - manual band bit, reset one, puts pll in manual band mode
// - six-bit manual band field, reset zero, picks band in manual mode
// - three-bit loop bandwidth code, reset 110, selects loop filter bandwidth
// - five-bit charge pump code, reset 10001, sets monotonic pump current
// - controller clock divider, reset 3, ratios 2,4,8,16
// - cross-point controller enable bit, reset one, switches controller
// - vco divider, reset 10, ratios 1,2,4,4
// - loop divider, reset 01, code 00 gives ratio two
// - loop divider codes 01,10,11 give ratios 4,8,16
// - pll enable bit, reset zero, switches on the clock multiplier
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module pcc_pll_config (
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [11:0]         i_paddr,
  input  wire logic [31:0]         i_pwdata,
  input  wire logic [5:0]          i_auto_band,
  output logic                     o_pready,
  output logic                     o_pslverr,
  output logic [31:0]              o_prdata,
  output pcc_pkg::pcc_cfg_s        o_cfg,
  output logic                     o_pll_controller_clock_en
);

  // ==========================================================================
  // address decode
  wire hit_band = (i_paddr == pcc_pkg::PCC_ADDR_BAND);
  wire hit_filt = (i_paddr == pcc_pkg::PCC_ADDR_FILT);
  wire hit_div  = (i_paddr == pcc_pkg::PCC_ADDR_DIV);
  wire hit_stat = (i_paddr == pcc_pkg::PCC_ADDR_STAT);
  wire hit_any  = hit_band | hit_filt | hit_div | hit_stat;
  wire setup    = i_psel & ~i_penable;
  wire access   = i_psel & i_penable & o_pready;
  wire wr_ok    = access & i_pwrite & ~o_pslverr;

  // ==========================================================================
  // configuration registers
  logic [7:0] band_r;
  logic [7:0] filt_r;
  logic [7:0] div_r;
  logic [7:0] band_nxt;
  logic [7:0] filt_nxt;
  logic [7:0] div_nxt;
  logic       pready_r;
  logic       pslverr_r;
  logic [31:0] prdata_r;
  pcc_pkg::pcc_cfg_s cfg_r;
  pcc_pkg::pcc_cfg_s cfg_nxt;

  wire [7:0] div_wdata = i_pwdata[7:0] & ~(8'h01 << pcc_pkg::PCC_DIV_RSVD_BIT);

  assign band_nxt = (wr_ok && hit_band) ? i_pwdata[7:0] : band_r;
  assign filt_nxt = (wr_ok && hit_filt) ? i_pwdata[7:0] : filt_r;
  assign div_nxt  = (wr_ok && hit_div)  ? div_wdata     : div_r;

  // ==========================================================================
  // decoded configuration
  wire       manual    = band_r[pcc_pkg::PCC_MANUAL_BIT];
  wire [5:0] man_band  = band_r[pcc_pkg::PCC_BAND_MSB:0];
  wire [1:0] ctl_code  = div_r[pcc_pkg::PCC_CTL_MSB:pcc_pkg::PCC_CTL_LSB];
  wire [1:0] vco_code  = div_r[pcc_pkg::PCC_VCO_MSB:pcc_pkg::PCC_VCO_LSB];
  wire [1:0] ref_code  = div_r[pcc_pkg::PCC_REF_MSB:0];
  wire [2:0] vco_ratio = (vco_code >= pcc_pkg::PCC_VCO_CAP) ? pcc_pkg::PCC_RATIO_FOUR
                       : 3'(pcc_pkg::PCC_RATIO_ONE << vco_code);

  assign cfg_nxt.pll_enable   = band_r[pcc_pkg::PCC_PLL_EN_BIT];
  assign cfg_nxt.manual_mode  = manual;
  assign cfg_nxt.vco_band     = manual ? man_band : i_auto_band;
  assign cfg_nxt.loop_bw_code = filt_r[pcc_pkg::PCC_BW_MSB:pcc_pkg::PCC_BW_LSB];
  assign cfg_nxt.pump_code    = filt_r[pcc_pkg::PCC_CP_MSB:0];
  assign cfg_nxt.ctrl_ratio   = 5'(pcc_pkg::PCC_RATIO_TWO << ctl_code);
  assign cfg_nxt.xpt_enable   = div_r[pcc_pkg::PCC_XPT_BIT];
  assign cfg_nxt.vco_ratio    = vco_ratio;
  assign cfg_nxt.ref_ratio    = 5'(pcc_pkg::PCC_RATIO_TWO << ref_code);

  // ==========================================================================
  // read mux; status shows the band currently in use
  wire [7:0] rd_byte = hit_band ? band_r
                     : hit_filt ? filt_r
                     : hit_div  ? div_r
                     : hit_stat ? {2'h0, cfg_r.vco_band}
                     : 8'h00;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      band_r <= pcc_pkg::PCC_RST_BAND;
      filt_r <= pcc_pkg::PCC_RST_FILT;
      div_r  <= pcc_pkg::PCC_RST_DIV;
    end else begin
      band_r <= band_nxt;
      filt_r <= filt_nxt;
      div_r  <= div_nxt;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & (~hit_any | (i_pwrite & hit_stat));
      prdata_r  <= (setup && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // config outputs are registered so the analog side sees clean levels
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  pcc_ctrl_div u_ctrl_div (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_enable (cfg_r.pll_enable),
    .i_code   (ctl_code),
    .o_pulse  (o_pll_controller_clock_en)
  );

  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_prdata  = prdata_r;
  assign o_cfg     = cfg_r;

  // ==========================================================================
  // checks
  a_manual_mode_out : assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_nrst |-> ##1 (o_cfg.manual_mode == $past(band_r[pcc_pkg::PCC_MANUAL_BIT])))
    else $error("manual mode output wrong");
  a_manual_band_use : assert property (@(posedge i_clock) disable iff (!i_nrst)
    manual |=> (o_cfg.vco_band == $past(band_r[5:0])))
    else $error("manual band not applied");
  a_loop_bw_code : assert property (@(posedge i_clock) disable iff (!i_nrst)
    (wr_ok && hit_filt) |=> ##1 (o_cfg.loop_bw_code == $past(i_pwdata[7:5], 2)))
    else $error("loop bandwidth code wrong");
  a_pump_code_out : assert property (@(posedge i_clock) disable iff (!i_nrst)
    (wr_ok && hit_filt) |=> ##1 (o_cfg.pump_code == $past(i_pwdata[4:0], 2)))
    else $error("pump code wrong");
  a_ctrl_ratio_map : assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_nrst && div_r[7:6] == 2'h3) |=> (o_cfg.ctrl_ratio == 5'h10))
    else $error("controller ratio wrong");
  a_pc_pulse_period : assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_pll_controller_clock_en && $stable(ctl_code) && ctl_code == 2'h0 && cfg_r.pll_enable)
    ##1 ($stable(ctl_code) && cfg_r.pll_enable) |=> o_pll_controller_clock_en)
    else $error("divide by two period wrong");
  a_xpt_enable_out : assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(div_r[4]) |=> o_cfg.xpt_enable)
    else $error("cross-point enable not applied");
  a_vco_ratio_map : assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_nrst && div_r[3]) |=> (o_cfg.vco_ratio == 3'h4))
    else $error("vco ratio wrong");
  a_ref_ratio_map : assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_nrst |-> ##1 (o_cfg.ref_ratio == (5'h02 << $past(div_r[1:0]))))
    else $error("reference ratio wrong");
  a_pll_enable_out : assert property (@(posedge i_clock) disable iff (!i_nrst)
    !cfg_r.pll_enable |=> !o_pll_controller_clock_en)
    else $error("controller clock runs while pll off");

endmodule : pcc_pll_config

// file: core/pcc_pkg.sv
// Purpose : shared constants and types of the pll clock configuration block
// Assumes : registers sit on a 32-bit apb bus, one aligned word per register
// Notes   : printed offsets are register indices; byte address is four times the index
package pcc_pkg;

  // ==========================================================================
  // register indices and byte addresses
  localparam logic [7:0]  PCC_IDX_BAND   = 8'h0a;
  localparam logic [7:0]  PCC_IDX_FILT   = 8'h0c;
  localparam logic [7:0]  PCC_IDX_DIV    = 8'h0d;
  localparam logic [7:0]  PCC_IDX_STAT   = 8'h0f;
  localparam logic [11:0] PCC_ADDR_BAND  = {2'h0, PCC_IDX_BAND, 2'h0};
  localparam logic [11:0] PCC_ADDR_FILT  = {2'h0, PCC_IDX_FILT, 2'h0};
  localparam logic [11:0] PCC_ADDR_DIV   = {2'h0, PCC_IDX_DIV, 2'h0};
  localparam logic [11:0] PCC_ADDR_STAT  = {2'h0, PCC_IDX_STAT, 2'h0};

  // ==========================================================================
  // reset values
  localparam logic [7:0]  PCC_RST_BAND   = 8'h40;
  localparam logic [7:0]  PCC_RST_FILT   = 8'hd1;
  localparam logic [7:0]  PCC_RST_DIV    = 8'hd9;

  // ==========================================================================
  // field positions
  localparam int PCC_PLL_EN_BIT   = 7;
  localparam int PCC_MANUAL_BIT   = 6;
  localparam int PCC_BAND_MSB     = 5;
  localparam int PCC_BW_MSB       = 7;
  localparam int PCC_BW_LSB       = 5;
  localparam int PCC_CP_MSB       = 4;
  localparam int PCC_CTL_MSB      = 7;
  localparam int PCC_CTL_LSB      = 6;
  localparam int PCC_XPT_BIT      = 4;
  localparam int PCC_VCO_MSB      = 3;
  localparam int PCC_VCO_LSB      = 2;
  localparam int PCC_REF_MSB      = 1;
  localparam int PCC_DIV_RSVD_BIT = 5;

  // ==========================================================================
  // ratio bases
  localparam logic [4:0]  PCC_RATIO_TWO  = 5'h02;
  localparam logic [2:0]  PCC_RATIO_ONE  = 3'h1;
  localparam logic [2:0]  PCC_RATIO_FOUR = 3'h4;
  localparam logic [1:0]  PCC_VCO_CAP    = 2'h2;

  // ==========================================================================
  // decoded configuration handed to the analog pll
  typedef struct packed {
    logic       pll_enable;
    logic       manual_mode;
    logic [5:0] vco_band;
    logic [2:0] loop_bw_code;
    logic [4:0] pump_code;
    logic [4:0] ctrl_ratio;
    logic       xpt_enable;
    logic [2:0] vco_ratio;
    logic [4:0] ref_ratio;
  } pcc_cfg_s;

endpackage : pcc_pkg

// file: core/pcc_ctrl_div.sv
// Purpose : one-cycle enable pulse at sample clock rate divided by 2, 4, 8 or 16
// Assumes : i_code comes from a register on the same clock
// Notes   : a code change takes effect at the next wrap or at once if count passed it
`timescale 1ns/10ps
module pcc_ctrl_div (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_enable,
  input  wire logic [1:0] i_code,
  output logic            o_pulse
);

  // ==========================================================================
  // divider counter
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       pulse_r;
  wire  [4:0] ratio = 5'(pcc_pkg::PCC_RATIO_TWO << i_code);
  wire  [3:0] term  = 4'(ratio - 5'h01);
  wire        wrap  = (cnt_r >= term);

  assign cnt_nxt = (!i_enable || wrap) ? 4'h0 : 4'(cnt_r + 4'h1);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r   <= 4'h0;
      pulse_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      pulse_r <= i_enable && wrap;
    end
  end

  assign o_pulse = pulse_r;

  a_pulse_gap_min : assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_pulse |=> !o_pulse) else $error("controller clock pulses too close");

endmodule : pcc_ctrl_div

// file: bench/testbench.sv
// Purpose : self-checking bench of the pll clock configuration registers
// Assumes : apb master drives on rising edges; outputs read just after an edge
// Notes   : fixed-seed lfsr stimulus; expectations from bench functions
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  // ==========================================================================
  // design and stimulus
  localparam logic [11:0] ad_band = pcc_pkg::PCC_ADDR_BAND;
  localparam logic [11:0] ad_filt = pcc_pkg::PCC_ADDR_FILT;
  localparam logic [11:0] ad_div  = pcc_pkg::PCC_ADDR_DIV;
  localparam logic [11:0] ad_stat = pcc_pkg::PCC_ADDR_STAT;
  logic              i_clock   = 1'b0;
  logic              i_nrst    = 1'b0;
  logic              i_psel    = 1'b0;
  logic              i_penable = 1'b0;
  logic              i_pwrite  = 1'b0;
  logic [11:0]       i_paddr   = 12'h000;
  logic [31:0]       i_pwdata  = 32'h0;
  logic [5:0]        i_auto_band = 6'h15;
  logic              o_pready, o_pslverr, o_pll_controller_clock_en;
  logic [31:0]       o_prdata, rd, r;
  logic              err;
  logic [7:0]        band_m = 8'h40, filt_m = 8'hd1, div_m = 8'hd9, p;
  pcc_pkg::pcc_cfg_s o_cfg, c;
  int                error_cnt = 0, compares = 0, n;
  always #4 i_clock = ~i_clock;
  pcc_pll_config i_pcc_pll_config (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_auto_band(i_auto_band), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .o_cfg(o_cfg), .o_pll_controller_clock_en(o_pll_controller_clock_en));
  // ==========================================================================
  // expectations
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic pcc_pkg::pcc_cfg_s exp_cfg(input logic [7:0] b, f, d, input logic [5:0] ab);
    pcc_pkg::pcc_cfg_s x;
    x.pll_enable   = b[7];
    x.manual_mode  = b[6];
    x.vco_band     = b[6] ? b[5:0] : ab;
    x.loop_bw_code = f[7:5];
    x.pump_code    = f[4:0];
    x.ctrl_ratio   = 5'h02 << d[7:6];
    x.xpt_enable   = d[4];
    x.vco_ratio    = (d[3:2] == 2'h0) ? 3'h1 : (d[3:2] == 2'h1) ? 3'h2 : 3'h4;
    x.ref_ratio    = 5'h02 << d[1:0];
    return x;
  endfunction : exp_cfg
  // ==========================================================================
  // apb master and checks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK(err, !(a == ad_band || a == ad_filt || a == ad_div))
    if (a == ad_band) band_m = d[7:0];
    if (a == ad_filt) filt_m = d[7:0];
    if (a == ad_div) div_m = d[7:0] & 8'hdf;
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(err, 1'b0)
    `CHK(rd, e)
  endtask : rd_chk
  task automatic cfg_chk;
    repeat (3) @(posedge i_clock);
    c = exp_cfg(band_m, filt_m, div_m, i_auto_band);
    `CHK(o_cfg, c)
  endtask : cfg_chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // scenarios
  initial begin
    repeat (10000) @(posedge i_clock);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd_chk(ad_band, 32'h40);
    rd_chk(ad_filt, 32'hd1);
    rd_chk(ad_div, 32'hd9);
    cfg_chk();
    // every divider code, bit 5 written high must read back low
    for (int k = 0; k < 4; k++) begin
      wr(ad_band, {24'h0, 2'h3, 6'(k * 21)});
      wr(ad_div, {24'h0, 2'(k), 1'b1, ~k[0], 2'(k), 2'(k)});
      rd_chk(ad_div, {24'h0, div_m});
      cfg_chk();
      repeat (40) @(posedge i_clock);
      for (n = 0; n < 60 && o_pll_controller_clock_en !== 1'b1; n++) @(posedge i_clock);
      for (n = 1; n < 60; n++) begin
        @(posedge i_clock);
        if (o_pll_controller_clock_en === 1'b1) break;
      end
      `CHK(5'(n), 5'h02 << k)
    end
    // pll off, automatic band: no controller pulses, status shows auto band
    wr(ad_band, 32'h3f);
    cfg_chk();
    p = 8'h0;
    repeat (40) begin
      @(posedge i_clock);
      if (o_pll_controller_clock_en !== 1'b0) p++;
    end
    `CHK(p, 8'h0)
    rd_chk(ad_stat, {26'h0, i_auto_band});
    apb(1'b0, 12'h040, 32'h0);
    `CHK(err, 1'b1)
    r = 32'hd375fd72;
    repeat (40) begin
      r = lfsr_next(r);
      i_auto_band <= r[29:24];
      wr(r[1:0] == 2'h0 ? ad_band : r[1:0] == 2'h1 ? ad_filt : r[1:0] == 2'h2 ? ad_div :
         r[8] ? ad_stat : 12'h044, r);
      cfg_chk();
      rd_chk(ad_stat, {26'h0, c.vco_band});
      rd_chk(ad_filt, {24'h0, filt_m});
    end
    // reset in mid-run brings every register back to its reset value
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_nrst <= 1'b1;
    band_m = 8'h40;
    filt_m = 8'hd1;
    div_m  = 8'hd9;
    rd_chk(ad_band, 32'h40);
    rd_chk(ad_filt, 32'hd1);
    rd_chk(ad_div, 32'hd9);
    cfg_chk();
    tally_and_finish();
  end
endmodule : testbench
